// *** hdl/usb_port_regs.svh ***
// Register offsets, fields, reset values and timing counts of the port state block
`ifndef USB_PORT_REGS_SVH
`define USB_PORT_REGS_SVH

`define OFF_COMMAND 8'h00
`define OFF_STATUS 8'h04
`define OFF_INT_ENABLE 8'h08
`define OFF_DEVICE_ADDR 8'h0c
`define OFF_PORT_STATUS 8'h10
`define OFF_CTRL_MODE 8'h14
`define OFF_EP_LIST 8'h18
`define OFF_SETUP_FLAGS 8'h1c
`define OFF_COMPLETE_FLAGS 8'h20
`define OFF_PRIME 8'h24
`define OFF_FLUSH 8'h28
`define OFF_EP_ENABLE 8'h2c

`define CMD_RUN_BIT 0
`define CMD_RESET_BIT 1
`define STAT_PORT_CHANGE_BIT 0
`define STAT_BUS_RESET_BIT 1
`define STAT_SUSPEND_BIT 2
`define PORT_RESUME_BIT 0
`define PORT_RESET_BIT 1
`define PORT_HS_BIT 2
`define PORT_SUSPENDED_BIT 3
`define PORT_WAKE_EN_BIT 4
`define ADDR_LSB 25
`define EP_LIST_LSB 11

`define MODE_RESET 2'h0
`define ADDR_RESET 7'h00
`define INTEN_RESET 3'h0
`define LINE_SE0 2'h0
`define LINE_J 2'h1

`define CLK_MHZ 25
`define BUS_RESET_NS 2500
`define BUS_RESET_CYC ((`BUS_RESET_NS * `CLK_MHZ + 999) / 1000)
`define SUSPEND_IDLE_US 3000
`define SUSPEND_IDLE_CYC (`SUSPEND_IDLE_US * `CLK_MHZ)
`define RESUME_DRIVE_US 2000
`define RESUME_DRIVE_CYC (`RESUME_DRIVE_US * `CLK_MHZ)

`endif

// *** hdl/usb_port_pkg.sv ***
// Types shared by the port state block
package usb_port_pkg;
    typedef enum logic [2:0] {
        ST_POWERED = 3'h0,
        ST_ATTACH = 3'h1,
        ST_BUS_RESET = 3'h2,
        ST_DEFAULT = 3'h3,
        ST_SUSPEND = 3'h4,
        ST_RESUME = 3'h5
    } port_state_e;
endpackage

// *** hdl/pin_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
        end
    end

    assign synced = sync_reg;
endmodule // pin_sync

// *** hdl/line_monitor.sv ***
// Upstream line watcher: bus reset, idle timeout and activity
`timescale 1ns/1ns
`include "usb_port_regs.svh"
module line_monitor #(
    parameter int RESET_CYC = `BUS_RESET_CYC,
    parameter int IDLE_CYC = `SUSPEND_IDLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic [1:0] line_state,
    output logic bus_reset,
    output logic idle_timeout,
    output logic line_active
);
    localparam int RW = $clog2(RESET_CYC + 1);
    localparam int IW = $clog2(IDLE_CYC + 1);
    localparam logic [RW-1:0] RESET_MAX = RW'(RESET_CYC);
    localparam logic [IW-1:0] IDLE_MAX = IW'(IDLE_CYC);

    logic [RW-1:0] se0_cnt_reg, se0_cnt_next;
    logic [IW-1:0] idle_cnt_reg, idle_cnt_next;

    always_comb begin
        se0_cnt_next = '0;
        idle_cnt_next = '0;
        if (enable && line_state == `LINE_SE0) begin
            se0_cnt_next = (se0_cnt_reg == RESET_MAX) ? se0_cnt_reg : se0_cnt_reg + 1'b1;
        end
        if (enable && line_state == `LINE_J) begin
            idle_cnt_next = (idle_cnt_reg == IDLE_MAX) ? idle_cnt_reg : idle_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            se0_cnt_reg <= '0;
            idle_cnt_reg <= '0;
        end else begin
            se0_cnt_reg <= se0_cnt_next;
            idle_cnt_reg <= idle_cnt_next;
        end
    end

    assign bus_reset = (se0_cnt_reg == RESET_MAX);
    assign idle_timeout = (idle_cnt_reg == IDLE_MAX);
    assign line_active = (line_state != `LINE_J);
endmodule // line_monitor

// *** hdl/usb_device_port_state_control.sv ***
// Port state, bring-up and bus reset control of a USB device controller
// What this block and its software do
// RULE_01: Stays disabled, pull-up off, until software sets run/stop.
// RULE_02: Software prepares endpoint zero queue heads before attach.
// RULE_03: Software selects device mode; resets controller first when leaving host mode.
// RULE_04: Software initialises control queue heads before enabling those endpoints.
// RULE_05: Software brings up in order: mode, queue heads, list pointer, interrupt, run.
// RULE_06: Endpoint zero is always an enabled control endpoint, no priming needed.
// RULE_07: Powered after reset, attach on run, default state after bus reset.
// RULE_08: Reports suspended, bus reset, port change and high-speed indications.
// RULE_09: Software tracks addressed and configured states and programs the address.
// RULE_10: Bus reset renegotiates speed, clears address, raises enabled interrupt.
// RULE_11: Bus reset disables all endpoints but zero and cancels primes.
// RULE_12: Setup and complete flags are cleared by writing ones back.
// RULE_13: Software waits for primes to clear, then flushes all endpoints.
// RULE_14: Bus reset is seen after 2.5 microseconds of SE0; port reset bit shows it live.
// RULE_15: Controller reset bit clears run/stop, detaches and resets registers.
// RULE_16: Port change marks default state reached, with speed shown.
// RULE_17: Idle or suspend signaling enters suspend, sets flag, interrupts if enabled.
// RULE_18: Suspend keeps address, configuration and all other state.
// RULE_19: Any non-idle upstream signaling resumes a suspended controller.
// RULE_20: Writing resume while suspended drives resume signaling upstream.
// RULE_21: Remote wakeup is disabled by reset until software enables it.
// RULE_22: Three milliseconds idle means suspend; suspended flag clears on resume.
// RULE_23: High-speed indication updates before port change is raised; hs_reg and the port change bit are registered on the same clock edge here.
`timescale 1ns/1ns
`include "usb_port_regs.svh"
module usb_device_port_state_control #(
    parameter int NUM_EP = 4,
    parameter int IDLE_CYC = `SUSPEND_IDLE_CYC,
    parameter int RESUME_CYC = `RESUME_DRIVE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] line_state,
    input wire logic host_chirp,
    input wire logic [NUM_EP-1:0] setup_rx,
    input wire logic [NUM_EP-1:0] xfer_done,
    input wire logic [NUM_EP-1:0] prime_done,
    output logic dm_pullup,
    output logic resume_k,
    output logic hs_port,
    output logic [6:0] dev_address,
    output logic [NUM_EP-1:0] ep_enable,
    output logic [NUM_EP-1:0] ep_prime,
    output logic irq
);
    localparam int CW = $clog2(RESUME_CYC + 1);
    localparam logic [CW-1:0] RESUME_LAST = CW'(RESUME_CYC - 1);
    localparam logic [NUM_EP-1:0] EP0_ONLY = NUM_EP'(1);

    logic [2:0] pin_s;
    logic bus_rst, idle_to, line_act;
    usb_port_pkg::port_state_e state_reg, state_next;
    logic run_reg, run_next;
    logic [1:0] mode_reg, mode_next;
    logic [31:0] eplist_reg, eplist_next;
    logic [6:0] addr_reg, addr_next;
    logic [2:0] inten_reg, inten_next;
    logic [2:0] stat_reg, stat_next;
    logic hs_reg, hs_next;
    logic chirp_reg, chirp_next;
    logic wake_reg, wake_next;
    logic [CW-1:0] rcnt_reg, rcnt_next;
    logic [NUM_EP-1:0] setup_reg, setup_next;
    logic [NUM_EP-1:0] compl_reg, compl_next;
    logic [NUM_EP-1:0] prime_reg, prime_next;
    logic [NUM_EP-1:0] epen_reg, epen_next;
    logic [31:0] prdata_reg, prdata_next;
    logic wr, hit, soft_rst, resume_req, enter_reset;

    pin_sync #(.WIDTH(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin({host_chirp, line_state}),
        .synced(pin_s)
    );

    line_monitor #(.RESET_CYC(`BUS_RESET_CYC), .IDLE_CYC(IDLE_CYC)) u_line (
        .pclk(pclk),
        .presetn(presetn),
        .enable(run_reg),
        .line_state(pin_s[1:0]),
        .bus_reset(bus_rst),
        .idle_timeout(idle_to),
        .line_active(line_act)
    );

    assign wr = psel && penable && pwrite;
    always_comb begin
        unique case (paddr)
            `OFF_COMMAND, `OFF_STATUS, `OFF_INT_ENABLE, `OFF_DEVICE_ADDR,
            `OFF_PORT_STATUS, `OFF_CTRL_MODE, `OFF_EP_LIST, `OFF_SETUP_FLAGS,
            `OFF_COMPLETE_FLAGS, `OFF_PRIME, `OFF_FLUSH, `OFF_EP_ENABLE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign soft_rst = wr && paddr == `OFF_COMMAND && pwdata[`CMD_RESET_BIT]; // RULE_15
    assign resume_req = wr && paddr == `OFF_PORT_STATUS && pwdata[`PORT_RESUME_BIT]
        && wake_reg && state_reg == usb_port_pkg::ST_SUSPEND; // RULE_20 RULE_21
    assign enter_reset = bus_rst && (state_reg == usb_port_pkg::ST_ATTACH
        || state_reg == usb_port_pkg::ST_DEFAULT || state_reg == usb_port_pkg::ST_SUSPEND);

    always_comb begin
        state_next = state_reg;
        run_next = run_reg;
        mode_next = mode_reg;
        eplist_next = eplist_reg;
        addr_next = addr_reg;
        inten_next = inten_reg;
        stat_next = stat_reg;
        hs_next = hs_reg;
        chirp_next = chirp_reg;
        wake_next = wake_reg;
        rcnt_next = rcnt_reg;
        prdata_next = prdata_reg;
        // Read data captured in the setup cycle
        if (psel && !penable && !pwrite) begin
            prdata_next = '0;
            unique case (paddr)
                `OFF_COMMAND: prdata_next[`CMD_RUN_BIT] = run_reg;
                `OFF_STATUS: prdata_next[2:0] = stat_reg; // RULE_08
                `OFF_INT_ENABLE: prdata_next[2:0] = inten_reg;
                `OFF_DEVICE_ADDR: prdata_next[`ADDR_LSB +: 7] = addr_reg;
                `OFF_PORT_STATUS: begin
                    prdata_next[`PORT_RESET_BIT] = state_reg == usb_port_pkg::ST_BUS_RESET; // RULE_14
                    prdata_next[`PORT_HS_BIT] = hs_reg; // RULE_08
                    prdata_next[`PORT_SUSPENDED_BIT] =
                        state_reg == usb_port_pkg::ST_SUSPEND; // RULE_08
                    prdata_next[`PORT_WAKE_EN_BIT] = wake_reg;
                end
                `OFF_CTRL_MODE: prdata_next[1:0] = mode_reg;
                `OFF_EP_LIST: prdata_next = eplist_reg;
                `OFF_SETUP_FLAGS: prdata_next[NUM_EP-1:0] = setup_reg;
                `OFF_COMPLETE_FLAGS: prdata_next[NUM_EP-1:0] = compl_reg;
                `OFF_PRIME: prdata_next[NUM_EP-1:0] = prime_reg;
                `OFF_EP_ENABLE: prdata_next[NUM_EP-1:0] = epen_reg;
                default: prdata_next = '0;
            endcase
        end
        // Write one to clear; new events win over the clear
        setup_next = setup_reg;
        compl_next = compl_reg;
        prime_next = prime_reg;
        epen_next = epen_reg;
        if (wr) begin
            unique case (paddr)
                `OFF_COMMAND: run_next = pwdata[`CMD_RUN_BIT];
                `OFF_STATUS: stat_next = stat_reg & ~pwdata[2:0];
                `OFF_INT_ENABLE: inten_next = pwdata[2:0];
                `OFF_DEVICE_ADDR: addr_next = pwdata[`ADDR_LSB +: 7];
                `OFF_PORT_STATUS: wake_next = pwdata[`PORT_WAKE_EN_BIT];
                `OFF_CTRL_MODE: mode_next = pwdata[1:0];
                `OFF_EP_LIST: eplist_next = {pwdata[31:`EP_LIST_LSB], 11'h000};
                `OFF_SETUP_FLAGS: setup_next = setup_reg & ~pwdata[NUM_EP-1:0]; // RULE_12
                `OFF_COMPLETE_FLAGS: compl_next = compl_reg & ~pwdata[NUM_EP-1:0]; // RULE_12
                `OFF_PRIME: prime_next = prime_reg | pwdata[NUM_EP-1:0];
                `OFF_FLUSH: prime_next = prime_reg & ~pwdata[NUM_EP-1:0];
                `OFF_EP_ENABLE: epen_next = pwdata[NUM_EP-1:0] | EP0_ONLY; // RULE_06
                default: ;
            endcase
        end
        setup_next = setup_next | setup_rx;
        compl_next = compl_next | xfer_done;
        prime_next = prime_next & ~prime_done;
        unique case (state_reg)
            usb_port_pkg::ST_POWERED: begin
                if (run_reg) state_next = usb_port_pkg::ST_ATTACH; // RULE_07
            end
            usb_port_pkg::ST_ATTACH: ;
            usb_port_pkg::ST_BUS_RESET: begin
                chirp_next = chirp_reg | pin_s[2];
                if (!bus_rst) begin
                    state_next = usb_port_pkg::ST_DEFAULT; // RULE_07
                    hs_next = chirp_reg; // RULE_10 RULE_23
                    stat_next[`STAT_PORT_CHANGE_BIT] = 1'b1; // RULE_16
                end
            end
            usb_port_pkg::ST_DEFAULT: begin
                if (idle_to) begin
                    state_next = usb_port_pkg::ST_SUSPEND; // RULE_17 RULE_22
                    stat_next[`STAT_SUSPEND_BIT] = 1'b1; // RULE_17
                end
            end
            usb_port_pkg::ST_SUSPEND: begin
                // Address and configuration untouched here
                if (line_act) begin
                    state_next = usb_port_pkg::ST_DEFAULT; // RULE_19 RULE_18
                    stat_next[`STAT_PORT_CHANGE_BIT] = 1'b1;
                end else if (resume_req) begin
                    state_next = usb_port_pkg::ST_RESUME; // RULE_20
                    rcnt_next = '0;
                end
            end
            usb_port_pkg::ST_RESUME: begin
                rcnt_next = rcnt_reg + 1'b1;
                if (rcnt_reg == RESUME_LAST) begin
                    state_next = usb_port_pkg::ST_DEFAULT; // RULE_22
                    stat_next[`STAT_PORT_CHANGE_BIT] = 1'b1;
                end
            end
            default: state_next = usb_port_pkg::ST_POWERED;
        endcase
        if (enter_reset) begin
            state_next = usb_port_pkg::ST_BUS_RESET;
            addr_next = `ADDR_RESET; // RULE_10
            stat_next[`STAT_BUS_RESET_BIT] = 1'b1; // RULE_10
            epen_next = EP0_ONLY; // RULE_11
            prime_next = '0; // RULE_11
            wake_next = 1'b0; // RULE_21
            chirp_next = 1'b0;
        end
        if (!run_reg) state_next = usb_port_pkg::ST_POWERED; // RULE_01
        if (soft_rst) begin
            state_next = usb_port_pkg::ST_POWERED; // RULE_15
            run_next = 1'b0; // RULE_15
            mode_next = `MODE_RESET;
            eplist_next = '0;
            addr_next = `ADDR_RESET;
            inten_next = `INTEN_RESET;
            stat_next = '0;
            hs_next = 1'b0;
            chirp_next = 1'b0;
            wake_next = 1'b0;
            rcnt_next = '0;
            setup_next = '0;
            compl_next = '0;
            prime_next = '0;
            epen_next = EP0_ONLY;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= usb_port_pkg::ST_POWERED; // RULE_07
            run_reg <= 1'b0; // RULE_01
            mode_reg <= `MODE_RESET;
            eplist_reg <= '0;
            addr_reg <= `ADDR_RESET;
            inten_reg <= `INTEN_RESET;
            stat_reg <= '0;
            hs_reg <= 1'b0;
            chirp_reg <= 1'b0;
            wake_reg <= 1'b0; // RULE_21
            rcnt_reg <= '0;
            setup_reg <= '0;
            compl_reg <= '0;
            prime_reg <= '0;
            epen_reg <= EP0_ONLY; // RULE_06
            prdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            run_reg <= run_next;
            mode_reg <= mode_next;
            eplist_reg <= eplist_next;
            addr_reg <= addr_next;
            inten_reg <= inten_next;
            stat_reg <= stat_next;
            hs_reg <= hs_next;
            chirp_reg <= chirp_next;
            wake_reg <= wake_next;
            rcnt_reg <= rcnt_next;
            setup_reg <= setup_next;
            compl_reg <= compl_next;
            prime_reg <= prime_next;
            epen_reg <= epen_next;
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign dm_pullup = state_reg != usb_port_pkg::ST_POWERED; // RULE_01
    assign resume_k = state_reg == usb_port_pkg::ST_RESUME; // RULE_20
    assign hs_port = hs_reg;
    assign dev_address = addr_reg;
    assign ep_enable = epen_reg | EP0_ONLY; // RULE_06
    assign ep_prime = prime_reg;
    assign irq = |(stat_reg & inten_reg); // RULE_10 RULE_17

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    attach_on_run_a: assert property ($rose(run_reg) |=> dm_pullup) // RULE_01
        else $error("pull-up not raised after run");
    detach_a: assert property (!run_reg |=> !dm_pullup) // RULE_07
        else $error("pull-up active while stopped");
    reset_effects_a: assert property (enter_reset && run_reg && !soft_rst && !wr |=>
        dev_address == 7'h00 && ep_enable == EP0_ONLY && ep_prime == '0
        && stat_reg[`STAT_BUS_RESET_BIT]) // RULE_11
        else $error("bus reset side effects missing");
    w1c_clear_a: assert property (wr && paddr == `OFF_SETUP_FLAGS && setup_rx == '0
        && !soft_rst |=> (setup_reg & $past(pwdata[NUM_EP-1:0])) == '0) // RULE_12
        else $error("setup flags not cleared by write");
    ctrl_reset_a: assert property (soft_rst |=> !run_reg ##1 !dm_pullup) // RULE_15
        else $error("controller reset left the port attached");
    speed_change_a: assert property (state_reg == usb_port_pkg::ST_BUS_RESET && !bus_rst
        && run_reg && !soft_rst |=> stat_reg[`STAT_PORT_CHANGE_BIT]
        && hs_port == $past(chirp_reg)) // RULE_23
        else $error("speed or port change wrong at reset end");
    suspend_entry_a: assert property (state_reg == usb_port_pkg::ST_DEFAULT && idle_to
        && !bus_rst && run_reg && !soft_rst |=> state_reg == usb_port_pkg::ST_SUSPEND
        && stat_reg[`STAT_SUSPEND_BIT]) // RULE_17
        else $error("suspend not entered after idle");
    suspend_keep_a: assert property (state_reg == usb_port_pkg::ST_SUSPEND && !bus_rst
        && !(wr && paddr inside {`OFF_DEVICE_ADDR, `OFF_COMMAND, `OFF_EP_ENABLE})
        |=> $stable(dev_address) && $stable(ep_enable)) // RULE_18
        else $error("state lost in suspend");
    wake_a: assert property (state_reg == usb_port_pkg::ST_SUSPEND && line_act && !bus_rst
        && run_reg && !soft_rst |=> state_reg == usb_port_pkg::ST_DEFAULT) // RULE_19
        else $error("no resume on bus activity");
    resume_hold_a: assert property ($rose(resume_k) && run_reg |-> resume_k[*8]) // RULE_20
        else $error("resume signaling too short");
    wake_gate_a: assert property (!wake_reg |=> !$rose(resume_k)) // RULE_21
        else $error("resume driven without wakeup enable");

    bus_reset_c: cover property (state_reg == usb_port_pkg::ST_BUS_RESET ##1
        state_reg == usb_port_pkg::ST_DEFAULT);
    suspend_c: cover property (state_reg == usb_port_pkg::ST_SUSPEND);
    remote_wake_c: cover property ($fell(resume_k));
    flush_c: cover property (wr && paddr == `OFF_FLUSH && ep_prime != '0);
endmodule // usb_device_port_state_control

// *** bench/usb_host_model.sv ***
// Upstream host and hub port model driving the device's line pins
`timescale 1ns/1ns
module usb_host_model (
    input wire logic pclk,
    input wire logic resume_k,
    output logic [1:0] line_state,
    output logic host_chirp
);
    logic [1:0] line_drv;
    initial begin
        line_drv = 2'h1;
        host_chirp = 1'b0;
    end
    // Device resume signaling shows as K on the wire
    assign line_state = resume_k ? 2'h2 : line_drv;
    // Holds a line level for n cycles; SE0 long enough is a bus reset
    task automatic drive(input logic [1:0] s, input int n, input logic c);
        @(posedge pclk);
        line_drv <= s;
        host_chirp <= c;
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
endmodule // usb_host_model

// *** bench/usb_device_port_state_control_tb_top.sv ***
// Testbench of the port state block
`timescale 1ns/1ns
`include "usb_port_regs.svh"
module usb_device_port_state_control_tb_top;
    localparam int IDLE = 200;
    localparam int RES = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic [1:0] line_state;
    logic host_chirp, dm_pullup, resume_k, hs_port, irq;
    logic [6:0] dev_address;
    logic [3:0] setup_rx = 4'h0, xfer_done = 4'h0, prime_done = 4'h0, ep_enable, ep_prime;
    int n_errors = 0, checked = 0, cycles = 0, n;
    always #20 pclk = ~pclk;
    usb_device_port_state_control #(.NUM_EP(4), .IDLE_CYC(IDLE), .RESUME_CYC(RES)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_state(line_state), .host_chirp(host_chirp), .setup_rx(setup_rx),
        .xfer_done(xfer_done), .prime_done(prime_done), .dm_pullup(dm_pullup),
        .resume_k(resume_k), .hs_port(hs_port), .dev_address(dev_address),
        .ep_enable(ep_enable), .ep_prime(ep_prime), .irq(irq));
    usb_host_model host_u (.pclk(pclk), .resume_k(resume_k), .line_state(line_state),
        .host_chirp(host_chirp));
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Compares a settled port level, caller at a falling edge; then steps one cycle
    task automatic pchk(input logic [31:0] got, input logic [31:0] exp, input string m);
        chk(got, exp, m);
        @(negedge pclk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ends when pready is high; only the bench timeout ends a stalled wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp, m);
    endtask
    task automatic pulse(input logic [3:0] s, input logic [3:0] x, input logic [3:0] p);
        @(posedge pclk);
        setup_rx <= s;
        xfer_done <= x;
        prime_done <= p;
        @(posedge pclk);
        setup_rx <= 4'h0;
        xfer_done <= 4'h0;
        prime_done <= 4'h0;
        @(negedge pclk);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        pchk(dm_pullup, 1'b0, "pullup at reset");
        pchk({irq, dev_address, ep_enable, ep_prime}, 16'h0010, "outputs at reset");
        rchk(`OFF_COMMAND, 32'h0, "command reset");
        rchk(`OFF_PORT_STATUS, 32'h0, "wake off at reset");
        xfer(1'b0, 8'h30, 32'h0);
        chk(err, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped read data");
        wr(`OFF_CTRL_MODE, 32'h2);
        wr(`OFF_EP_LIST, 32'hfffff800);
        wr(`OFF_INT_ENABLE, 32'h7);
        rchk(`OFF_CTRL_MODE, 32'h2, "mode");
        wr(`OFF_COMMAND, 32'h1);
        // Run lands at the access edge, attach one edge later
        @(negedge pclk);
        pchk(dm_pullup, 1'b1, "attach");
        wr(`OFF_DEVICE_ADDR, 32'h0a000000);
        wr(`OFF_EP_ENABLE, 32'hf);
        wr(`OFF_PRIME, 32'he);
        pchk({dev_address, ep_enable, ep_prime}, 15'h05fe, "programmed");
        host_u.drive(`LINE_SE0, 80, 1'b1);
        rchk(`OFF_PORT_STATUS, 32'h2, "reset live");
        pchk({irq, dev_address, ep_enable, ep_prime}, 16'h8010, "bus reset effects");
        host_u.drive(`LINE_J, 6, 1'b0);
        rchk(`OFF_PORT_STATUS, 32'h4, "high speed");
        rchk(`OFF_STATUS, 32'h3, "reset and change");
        wr(`OFF_STATUS, rd);
        rchk(`OFF_STATUS, 32'h0, "status cleared");
        pulse(4'h1, 4'h4, 4'h0);
        rchk(`OFF_SETUP_FLAGS, 32'h1, "setup flag");
        wr(`OFF_SETUP_FLAGS, rd);
        rchk(`OFF_SETUP_FLAGS, 32'h0, "setup cleared");
        rchk(`OFF_COMPLETE_FLAGS, 32'h4, "complete flag");
        wr(`OFF_COMPLETE_FLAGS, rd);
        rchk(`OFF_COMPLETE_FLAGS, 32'h0, "complete cleared");
        wr(`OFF_PRIME, 32'h3);
        pulse(4'h0, 4'h0, 4'h2);
        pchk(ep_prime, 4'h1, "prime done");
        rchk(`OFF_PRIME, 32'h1, "prime bits read");
        wr(`OFF_FLUSH, 32'hffffffff);
        pchk(ep_prime, 4'h0, "flushed");
        host_u.drive(`LINE_SE0, 80, 1'b0);
        host_u.drive(`LINE_J, 6, 1'b0);
        pchk(hs_port, 1'b0, "full speed");
        wr(`OFF_STATUS, 32'h7);
        wr(`OFF_DEVICE_ADDR, 32'h0a000000);
        wr(`OFF_PORT_STATUS, 32'h10);
        host_u.drive(`LINE_J, IDLE + 20, 1'b0);
        rchk(`OFF_STATUS, 32'h4, "suspend flag");
        rchk(`OFF_PORT_STATUS, 32'h18, "suspended");
        pchk({irq, dev_address}, 8'h85, "suspend keeps address");
        wr(`OFF_STATUS, 32'h7);
        wr(`OFF_PORT_STATUS, 32'h11);
        n = 0;
        while (resume_k !== 1'b1 && n < 10) begin
            @(negedge pclk);
            n++;
        end
        n = 0;
        while (resume_k === 1'b1 && n < 100) begin
            n++;
            @(negedge pclk);
        end
        chk(n, RES, "resume width");
        rchk(`OFF_PORT_STATUS, 32'h10, "resumed");
        wr(`OFF_PORT_STATUS, 32'h11);
        repeat (4) pchk(resume_k, 1'b0, "resume refused awake");
        wr(`OFF_PORT_STATUS, 32'h0);
        host_u.drive(`LINE_J, IDLE + 20, 1'b0);
        wr(`OFF_PORT_STATUS, 32'h1);
        repeat (4) pchk(resume_k, 1'b0, "resume refused no wake");
        host_u.drive(2'h2, 10, 1'b0);
        host_u.drive(`LINE_J, 6, 1'b0);
        rchk(`OFF_PORT_STATUS, 32'h0, "host activity resumes");
        wr(`OFF_COMMAND, 32'h2);
        pchk({dm_pullup, dev_address}, 8'h00, "soft reset detach");
        rchk(`OFF_COMMAND, 32'h0, "run cleared");
        print_verdict();
    end
endmodule // usb_device_port_state_control_tb_top
